// ---- src/local_bus_port.sv ----
// Local processor bus port: slave capture, master cycles, arbitration
// Notes on behaviour
// - As slave, capture 32-bit address on edge where start strobe is low
// - As master, drive address after a clock edge; inputs otherwise
// - Register offset decoded from lowest 12 address bits only
// - Current bus owner asserts busy; request, grant, busy form handshake
// - Master asserts busy from clock edge, negates before releasing
// - Busy input sampled on clock edges to see if bus is taken
// - Optional asynchronous arbitration mode replaces synchronous handshake
// - At reset burst strap with size bit 1 select master/slave mode
// - As slave, drive transfer error to fail the current transfer
// - As master, sample transfer error on clock edge
// - Acknowledge plus error together means retry, not error
// - Arbiter grant lets device become master; grant sampled on edges
// - Master-enable strap high during PCI reset sets bus master enable
// - Bus request asserted and released from clock edges
// - Slave ends normal cycles with acknowledge, negated before release
`include "local_bus_defs.svh"
module local_bus_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pci_reset_n,
  input wire logic async_arb_mode,
  input wire logic transfer_start_n_i,
  output logic transfer_start_n_o,
  output logic transfer_start_n_oe_n,
  input wire logic [`ADDR_W-1:0] addr_i,
  output logic [`ADDR_W-1:0] addr_o,
  output logic addr_oe_n,
  input wire logic [`SIZE_W-1:0] byte_count_code_i,
  output logic [`SIZE_W-1:0] byte_count_code_o,
  output logic byte_count_code_oe_n,
  input wire logic transfer_ack_n_i,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe_n,
  input wire logic transfer_error_n_i,
  output logic transfer_error_n_o,
  output logic transfer_error_n_oe_n,
  input wire logic register_chip_select_n,
  input wire logic pci_window_select_n,
  input wire logic slave_image_select,
  output logic arb_request_n,
  input wire logic arb_grant_n,
  input wire logic bus_occupied_n_i,
  output logic bus_occupied_n_o,
  output logic bus_occupied_n_oe_n,
  input wire logic burst_data_strap,
  input wire logic master_enable_strap,
  output logic [`STRAP_W-1:0] mode_strap,
  output logic bus_master_enable,
  output logic slave_start,
  output logic slave_is_reg,
  output logic [`REG_OFF_W-1:0] slave_offset,
  output logic [`ADDR_W-1:0] slave_addr,
  output logic [`SIZE_W-1:0] slave_size,
  output logic slave_image,
  input wire logic slave_done,
  input wire logic slave_fail,
  input wire logic slave_retry,
  input wire logic master_go,
  input wire logic [`ADDR_W-1:0] master_addr,
  input wire logic [`SIZE_W-1:0] master_size,
  output logic master_busy,
  output logic master_done,
  output logic master_error,
  output logic master_retried
);
  local_bus_pkg::slave_state_e s_q, s_d;
  local_bus_pkg::master_state_e m_q, m_d;
  logic [`CS_CNT_W-1:0] cnt_q, cnt_d;
  logic [`ADDR_W-1:0] saddr_q, maddr_q;
  logic [`SIZE_W-1:0] ssize_q, msize_q;
  logic simg_q, sreg_q, sstart_q;
  logic ack_n_q, ack_n_d, err_n_q, err_n_d;
  logic ts_n_q;
  logic mdone_q, merr_q, mretry_q;
  logic [`STRAP_W-1:0] strap_q;
  logic strap_done_q, bme_q;
  logic owned, want, sel_hit, ts_seen, hit_now, m_end;
  logic ack_in, err_in;
  // Arbitration handshake lives in its own module
  bus_arbitration arb (
    .clk(clk),
    .rstn(rstn),
    .want(want),
    .async_mode(async_arb_mode),
    .arb_grant_n(arb_grant_n),
    .bus_occupied_n_i(bus_occupied_n_i),
    .arb_request_n(arb_request_n),
    .bus_occupied_n_o(bus_occupied_n_o),
    .bus_occupied_n_oe_n(bus_occupied_n_oe_n),
    .owned(owned)
  );
  // Slave decode; our own start strobe must not look like a slave hit
  assign sel_hit = !register_chip_select_n || !pci_window_select_n;
  assign ts_seen = !transfer_start_n_i && !owned;
  assign hit_now = (s_q == local_bus_pkg::S_IDLE) ? ts_seen && sel_hit
                 : (s_q == local_bus_pkg::S_SEL) && sel_hit;
  // Slave sequencing: select, wait on user, acknowledge, negate
  always_comb begin
    s_d = s_q;
    cnt_d = cnt_q;
    ack_n_d = 1'b1;
    err_n_d = 1'b1;
    case (s_q)
      local_bus_pkg::S_IDLE: begin
        cnt_d = '0;
        if (ts_seen) begin
          s_d = sel_hit ? local_bus_pkg::S_WAIT : local_bus_pkg::S_SEL;
        end
      end
      local_bus_pkg::S_SEL: begin
        cnt_d = cnt_q + 1'b1;
        if (sel_hit) begin
          s_d = local_bus_pkg::S_WAIT;
        end else if (cnt_q == `CS_CNT_W'(`CS_WAIT_MAX - 1)) begin
          s_d = local_bus_pkg::S_IDLE; // Not for us
        end
      end
      local_bus_pkg::S_WAIT: begin
        if (slave_done) begin
          s_d = local_bus_pkg::S_ACK;
          ack_n_d = slave_fail && !slave_retry;
          err_n_d = !(slave_fail || slave_retry);
        end
      end
      local_bus_pkg::S_ACK: s_d = local_bus_pkg::S_NEG;
      local_bus_pkg::S_NEG: s_d = local_bus_pkg::S_IDLE;
      default: s_d = local_bus_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= local_bus_pkg::S_IDLE;
      cnt_q <= '0;
      ack_n_q <= 1'b1;
      err_n_q <= 1'b1;
    end else begin
      s_q <= s_d;
      cnt_q <= cnt_d;
      ack_n_q <= ack_n_d;
      err_n_q <= err_n_d;
    end
  end
  // Address and qualified signals captured with the start strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      saddr_q <= '0;
      ssize_q <= '0;
      simg_q <= 1'b0;
    end else if (s_q == local_bus_pkg::S_IDLE && ts_seen) begin
      saddr_q <= addr_i;
      ssize_q <= byte_count_code_i;
      simg_q <= slave_image_select;
    end
  end
  // Start pulse and register-vs-window flag taken at the select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sstart_q <= 1'b0;
      sreg_q <= 1'b0;
    end else begin
      sstart_q <= hit_now;
      if (hit_now) begin
        sreg_q <= !register_chip_select_n;
      end
    end
  end
  // Offset comes from the latched address; a chip select that lands in
  // the strobe cycle still sees the captured address one edge later
  assign slave_addr = saddr_q;
  assign slave_offset = saddr_q[`REG_OFF_W-1:0];
  assign slave_size = ssize_q;
  assign slave_image = simg_q;
  assign slave_is_reg = sreg_q;
  assign slave_start = sstart_q;
  // Response pins driven in the assert and negate cycles only
  assign transfer_ack_n_o = ack_n_q;
  assign transfer_error_n_o = err_n_q;
  assign transfer_ack_n_oe_n = !(s_q == local_bus_pkg::S_ACK
                              || s_q == local_bus_pkg::S_NEG);
  assign transfer_error_n_oe_n = transfer_ack_n_oe_n;
  // Master termination decode; both low is a retry
  assign ack_in = !transfer_ack_n_i;
  assign err_in = !transfer_error_n_i;
  assign m_end = (m_q == local_bus_pkg::M_DATA) && (ack_in || err_in);
  // Master sequencing
  always_comb begin
    m_d = m_q;
    case (m_q)
      local_bus_pkg::M_IDLE: if (master_go) m_d = local_bus_pkg::M_ARB;
      local_bus_pkg::M_ARB: if (owned) m_d = local_bus_pkg::M_ADDR;
      local_bus_pkg::M_ADDR: m_d = local_bus_pkg::M_DATA;
      local_bus_pkg::M_DATA: if (m_end) m_d = local_bus_pkg::M_IDLE;
      default: m_d = local_bus_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_q <= local_bus_pkg::M_IDLE;
      maddr_q <= '0;
      msize_q <= '0;
      ts_n_q <= 1'b1;
    end else begin
      m_q <= m_d;
      ts_n_q <= !(m_d == local_bus_pkg::M_ADDR); // Rescinded in data phase
      if (m_q == local_bus_pkg::M_IDLE && master_go) begin
        maddr_q <= master_addr;
        msize_q <= master_size;
      end
    end
  end
  // Outcome pulses, one cycle each
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mdone_q <= 1'b0;
      merr_q <= 1'b0;
      mretry_q <= 1'b0;
    end else begin
      mdone_q <= m_end && ack_in && !err_in;
      merr_q <= m_end && err_in && !ack_in;
      mretry_q <= m_end && ack_in && err_in;
    end
  end
  // Request ownership until the cycle ends; keeps bus during data phase
  assign want = (m_q != local_bus_pkg::M_IDLE) && !m_end;
  assign master_busy = (m_q != local_bus_pkg::M_IDLE);
  assign master_done = mdone_q;
  assign master_error = merr_q;
  assign master_retried = mretry_q;
  // Master pins float unless we own the bus and run a cycle
  assign addr_o = maddr_q;
  assign byte_count_code_o = msize_q;
  assign transfer_start_n_o = ts_n_q;
  assign addr_oe_n = !(owned && (m_q == local_bus_pkg::M_ADDR
                    || m_q == local_bus_pkg::M_DATA));
  assign byte_count_code_oe_n = addr_oe_n;
  assign transfer_start_n_oe_n = addr_oe_n;
  // Straps: mode taken at the first edge after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_q <= 1'b0;
      strap_q <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q <= {burst_data_strap, byte_count_code_i[`SIZE_UPPER_BIT]};
    end
  end
  // Master enable follows the strap for as long as PCI reset is held
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bme_q <= 1'b0;
    end else if (!pci_reset_n) begin
      bme_q <= master_enable_strap;
    end
  end
  assign mode_strap = strap_q;
  assign bus_master_enable = bme_q;
  slave_capture_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q == local_bus_pkg::S_IDLE && ts_seen |=> saddr_q == $past(addr_i))
    else $error("slave address not captured");
  reg_offset_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q == local_bus_pkg::S_IDLE && ts_seen
    |=> slave_offset == $past(addr_i[`REG_OFF_W-1:0]))
    else $error("offset not low address bits");
  ack_negate_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q == local_bus_pkg::S_ACK |=> !transfer_ack_n_oe_n && transfer_ack_n_o
    ##1 transfer_ack_n_oe_n)
    else $error("acknowledge not negated before release");
  slave_error_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q == local_bus_pkg::S_WAIT && slave_done && slave_fail && !slave_retry
    |=> !transfer_error_n_o && transfer_ack_n_o && !transfer_error_n_oe_n)
    else $error("slave error not driven");
  master_retry_a: assert property (@(posedge clk) disable iff (!rstn)
    m_q == local_bus_pkg::M_DATA && ack_in && err_in
    |=> master_retried && !master_error && !master_done)
    else $error("retry misread");
  master_error_a: assert property (@(posedge clk) disable iff (!rstn)
    m_q == local_bus_pkg::M_DATA && err_in && !ack_in
    |=> master_error && !master_retried)
    else $error("error not reported");
  float_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    m_q == local_bus_pkg::M_IDLE |-> addr_oe_n && transfer_start_n_oe_n)
    else $error("master pins driven while idle");
  start_strobe_a: assert property (@(posedge clk) disable iff (!rstn)
    m_q == local_bus_pkg::M_ARB && owned
    |=> !transfer_start_n_o && !addr_oe_n ##1 transfer_start_n_o)
    else $error("start strobe wrong");
  bme_strap_a: assert property (@(posedge clk) disable iff (!rstn)
    !pci_reset_n |=> bus_master_enable == $past(master_enable_strap))
    else $error("master enable not strapped");
  cover_reg_access: cover property (@(posedge clk) disable iff (!rstn)
    slave_start && slave_is_reg ##[1:20] s_q == local_bus_pkg::S_NEG);
  cover_master_ok: cover property (@(posedge clk) disable iff (!rstn)
    master_go ##[1:40] master_done);
  cover_master_retry: cover property (@(posedge clk) disable iff (!rstn)
    master_retried);
endmodule : local_bus_port

// ---- shared/local_bus_defs.svh ----
// Constants for the local processor bus port
`ifndef LOCAL_BUS_DEFS_SVH
`define LOCAL_BUS_DEFS_SVH
`define ADDR_W 32
`define REG_OFF_W 12
`define SIZE_W 2
`define SIZE_UPPER_BIT 1
`define CS_WAIT_MAX 3
`define CS_CNT_W 2
`define STRAP_W 2
`endif

// ---- shared/local_bus_pkg.sv ----
// State types for the local processor bus port
package local_bus_pkg;
  typedef enum logic [1:0] {A_IDLE, A_REQ, A_OWN, A_NEG} arb_state_e;
  typedef enum logic [2:0] {S_IDLE, S_SEL, S_WAIT, S_ACK, S_NEG}
    slave_state_e;
  typedef enum logic [1:0] {M_IDLE, M_ARB, M_ADDR, M_DATA} master_state_e;
endpackage : local_bus_pkg

// ---- src/bus_arbitration.sv ----
// Three-wire request/grant/busy arbitration for the local bus
module bus_arbitration (
  input wire logic clk,
  input wire logic rstn,
  input wire logic want,
  input wire logic async_mode,
  input wire logic arb_grant_n,
  input wire logic bus_occupied_n_i,
  output logic arb_request_n,
  output logic bus_occupied_n_o,
  output logic bus_occupied_n_oe_n,
  output logic owned
);
  local_bus_pkg::arb_state_e st_q, st_d;
  logic g1_q, g2_q, b1_q, b2_q;
  logic req_n_q, req_n_d, busy_n_q, busy_n_d;
  logic grant_n, occ_n, may_take;

  // Two-flop synchronisers for the asynchronous arbitration mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      g1_q <= 1'b1;
      g2_q <= 1'b1;
      b1_q <= 1'b1;
      b2_q <= 1'b1;
    end else begin
      g1_q <= arb_grant_n;
      g2_q <= g1_q;
      b1_q <= bus_occupied_n_i;
      b2_q <= b1_q;
    end
  end

  // Async mode costs two cycles of latency on grant and busy
  assign grant_n = async_mode ? g2_q : arb_grant_n;
  assign occ_n = async_mode ? b2_q : bus_occupied_n_i;
  assign may_take = !grant_n && occ_n;

  // Next state and pin levels
  always_comb begin
    st_d = st_q;
    req_n_d = req_n_q;
    busy_n_d = busy_n_q;
    case (st_q)
      local_bus_pkg::A_IDLE: begin
        if (want) begin
          st_d = local_bus_pkg::A_REQ;
          req_n_d = 1'b0;
        end
      end
      local_bus_pkg::A_REQ: begin
        if (!want) begin
          st_d = local_bus_pkg::A_IDLE;
          req_n_d = 1'b1;
        end else if (may_take) begin
          st_d = local_bus_pkg::A_OWN;
          req_n_d = 1'b1;
          busy_n_d = 1'b0;
        end
      end
      local_bus_pkg::A_OWN: begin
        if (!want) begin
          st_d = local_bus_pkg::A_NEG;
          busy_n_d = 1'b1;
        end
      end
      local_bus_pkg::A_NEG: st_d = local_bus_pkg::A_IDLE;
      default: st_d = local_bus_pkg::A_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= local_bus_pkg::A_IDLE;
      req_n_q <= 1'b1;
      busy_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      req_n_q <= req_n_d;
      busy_n_q <= busy_n_d;
    end
  end

  assign arb_request_n = req_n_q;
  assign bus_occupied_n_o = busy_n_q;
  assign owned = (st_q == local_bus_pkg::A_OWN);
  // Busy pin driven while owning and for the negation cycle
  assign bus_occupied_n_oe_n = !(owned || st_q == local_bus_pkg::A_NEG);

  busy_release_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(bus_occupied_n_oe_n) |-> $past(bus_occupied_n_o) == 1'b1)
    else $error("busy released without negation");
  grant_take_a: assert property (@(posedge clk) disable iff (!rstn)
    st_q == local_bus_pkg::A_REQ && want && may_take
    |=> owned && arb_request_n && !bus_occupied_n_o)
    else $error("grant not taken");
  owner_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    owned |-> !bus_occupied_n_o && !bus_occupied_n_oe_n)
    else $error("owner not showing busy");
endmodule : bus_arbitration

// ---- bench/far_side_model.sv ----
// Arbiter and addressed slave model on the far side of the local bus
module far_side_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic arb_request_n,
  input wire logic dev_start_n,
  input wire logic [1:0] resp_mode,
  input wire logic [3:0] resp_wait,
  output logic arb_grant_n,
  output logic m_ack_n,
  output logic m_err_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic ph_q;
  // Grant one cycle after a request, withdrawn one cycle after it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arb_grant_n <= 1'b1;
    end else begin
      arb_grant_n <= arb_request_n;
    end
  end
  // Answer the device strobe after resp_wait cycles for one cycle;
  // lines then fall back to their pull-ups, so negate and release match
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 1'b0;
      cnt_q <= 4'h0;
      m_ack_n <= 1'b1;
      m_err_n <= 1'b1;
    end else begin
      m_ack_n <= 1'b1;
      m_err_n <= 1'b1;
      if (!ph_q && !dev_start_n) begin
        ph_q <= 1'b1;
        cnt_q <= resp_wait;
      end else if (ph_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (ph_q) begin
        ph_q <= 1'b0;
        m_ack_n <= resp_mode == 2'h1;
        m_err_n <= resp_mode == 2'h0;
      end
    end
  end
endmodule : far_side_model

// ---- bench/local_bus_port_tb.sv ----
// Self-checking bench for the local processor bus port
`include "local_bus_defs.svh"
module local_bus_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, pci_reset_n, async_arb_mode, tb_start_n, ext_busy_n;
  logic transfer_start_n_i, transfer_start_n_o, transfer_start_n_oe_n;
  logic [`ADDR_W-1:0] addr_i, addr_o, tb_addr, slave_addr, master_addr;
  logic addr_oe_n, byte_count_code_oe_n, dev_start_n, m_ack_n, m_err_n;
  logic [`SIZE_W-1:0] byte_count_code_i, byte_count_code_o, tb_size;
  logic [`SIZE_W-1:0] slave_size, master_size;
  logic transfer_ack_n_i, transfer_ack_n_o, transfer_ack_n_oe_n;
  logic transfer_error_n_i, transfer_error_n_o, transfer_error_n_oe_n;
  logic register_chip_select_n, pci_window_select_n, slave_image_select;
  logic arb_request_n, arb_grant_n, bus_occupied_n_i, bus_occupied_n_o;
  logic bus_occupied_n_oe_n, burst_data_strap, master_enable_strap;
  logic [`STRAP_W-1:0] mode_strap;
  logic [`REG_OFF_W-1:0] slave_offset;
  logic bus_master_enable, slave_start, slave_is_reg, slave_image;
  logic slave_done, slave_fail, slave_retry, master_go, master_busy;
  logic master_done, master_error, master_retried;
  logic [1:0] resp_mode;
  logic [3:0] resp_wait;
  int num_errors, samples_checked, n_sync, n_async, n_x;
  // Pulled-up pins: any low driver wins, released drivers read high
  assign dev_start_n = transfer_start_n_oe_n | transfer_start_n_o;
  assign transfer_start_n_i = tb_start_n & dev_start_n;
  assign transfer_ack_n_i = m_ack_n & (transfer_ack_n_oe_n | transfer_ack_n_o);
  assign transfer_error_n_i = m_err_n &
    (transfer_error_n_oe_n | transfer_error_n_o);
  assign bus_occupied_n_i = ext_busy_n &
    (bus_occupied_n_oe_n | bus_occupied_n_o);
  assign addr_i = addr_oe_n ? tb_addr : addr_o;
  assign byte_count_code_i = byte_count_code_oe_n ? tb_size
    : byte_count_code_o;
  local_bus_port dut_u (.*);
  far_side_model model_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Outside master access; select arrives dly edges after the strobe
  task automatic slave_acc(input logic [31:0] a, input int dly,
    input logic is_reg, input logic [1:0] kind);
    @(posedge clk);
    tb_start_n <= 1'b0;
    tb_addr <= a;
    tb_size <= 2'h2;
    slave_image_select <= a[4];
    repeat (dly) begin
      @(posedge clk);
      tb_start_n <= 1'b1;
      tb_addr <= ~a;
      slave_image_select <= ~a[4];
      tb_size <= 2'h1;
    end
    register_chip_select_n <= !is_reg;
    pci_window_select_n <= is_reg;
    @(posedge clk);
    tb_start_n <= 1'b1;
    tb_addr <= ~a;
    slave_image_select <= ~a[4];
    tb_size <= 2'h1;
    register_chip_select_n <= 1'b1;
    pci_window_select_n <= 1'b1;
    #1;
    chk("slave_start", dly < 4, slave_start);
    chk("addr_oe_n", 1, addr_oe_n);
    if (dly > 3) return;
    chk("slave_addr", a, slave_addr);
    chk("slave_offset", a[11:0], slave_offset);
    chk("slave_is_reg", is_reg, slave_is_reg);
    chk("slave_image", a[4], slave_image);
    chk("slave_size", 2'h2, slave_size);
    @(posedge clk);
    slave_done <= 1'b1;
    slave_fail <= kind == 2'h1;
    slave_retry <= kind == 2'h2;
    @(posedge clk);
    slave_done <= 1'b0;
    slave_fail <= 1'b0;
    slave_retry <= 1'b0;
    #1;
    chk("ack wire", kind == 2'h1, transfer_ack_n_i);
    chk("err wire", kind == 2'h0, transfer_error_n_i);
    @(posedge clk);
    #1;
    chk("ack negate", 2'h2, {transfer_ack_n_o, transfer_ack_n_oe_n});
    chk("err negate", 2'h2, {transfer_error_n_o, transfer_error_n_oe_n});
    @(posedge clk);
    #1;
    chk("ack release", 1, transfer_ack_n_oe_n);
  endtask : slave_acc
  // Device-mastered cycle; n returns cycles from request to ownership
  task automatic master_cyc(input logic [31:0] a, input logic [1:0] kind,
    input logic am, input logic occ, output int n);
    logic last;
    last = 1'b0;
    @(posedge clk);
    async_arb_mode <= am;
    ext_busy_n <= !occ;
    resp_mode <= kind;
    master_go <= 1'b1;
    master_addr <= a;
    master_size <= 2'h1;
    @(posedge clk);
    master_go <= 1'b0;
    // Request goes out one edge after the go is taken
    @(posedge clk);
    #1;
    chk("request", 0, arb_request_n);
    if (occ) begin
      repeat (6) @(posedge clk);
      #1;
      chk("busy held off", 1, bus_occupied_n_oe_n);
      chk("strobe held off", 1, transfer_start_n_oe_n);
      @(posedge clk) ext_busy_n <= 1'b1;
    end
    for (n = 0; n < 20 && bus_occupied_n_oe_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk("busy driven", 0, {bus_occupied_n_o, bus_occupied_n_oe_n});
    chk("request off", 1, arb_request_n);
    @(posedge clk);
    #1;
    chk("strobe", 0, {transfer_start_n_o, transfer_start_n_oe_n});
    chk("addr_o", a, addr_o);
    chk("addr_oe_n", 0, addr_oe_n);
    chk("size_oe_n", 0, byte_count_code_oe_n);
    chk("size_o", 2'h1, byte_count_code_o);
    for (int i = 0; i < 20 && !(master_done | master_error | master_retried);
      i++) begin
      @(posedge clk);
      #1;
    end
    chk("done", kind == 2'h0, master_done);
    chk("error", kind == 2'h1, master_error);
    chk("retried", kind == 2'h2, master_retried);
    for (int i = 0; i < 6 && bus_occupied_n_oe_n === 1'b0; i++) begin
      last = bus_occupied_n_o;
      @(posedge clk);
      #1;
    end
    chk("busy negated", 1, last);
    chk("busy float", 1, bus_occupied_n_oe_n);
    chk("addr float", 1, addr_oe_n);
    chk("master_busy", 0, master_busy);
  endtask : master_cyc
  // Watchdog well beyond the hundred-odd cycles the tests need
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {rstn, pci_reset_n, async_arb_mode, master_go} = 4'h0;
    {slave_done, slave_fail, slave_retry} = 3'h0;
    {tb_start_n, ext_busy_n, register_chip_select_n} = 3'h7;
    {pci_window_select_n, slave_image_select} = 2'h2;
    {burst_data_strap, master_enable_strap} = 2'h3;
    {tb_addr, master_addr, tb_size, master_size} = '0;
    resp_mode = 2'h0;
    resp_wait = 4'h2;
    {num_errors, samples_checked} = 0;
    repeat (11) @(posedge clk);
    #1;
    chk("oe in reset", 5'h1F, {addr_oe_n, transfer_start_n_oe_n,
      transfer_ack_n_oe_n, transfer_error_n_oe_n, bus_occupied_n_oe_n});
    @(posedge clk) rstn <= 1'b1;
    @(posedge clk) pci_reset_n <= 1'b1;
    #1;
    chk("mode_strap", 2'h2, mode_strap);
    chk("master enable", 1, bus_master_enable);
    @(posedge clk) master_enable_strap <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("enable held", 1, bus_master_enable);
    @(posedge clk) pci_reset_n <= 1'b0;
    @(posedge clk) pci_reset_n <= 1'b1;
    #1;
    chk("enable cleared", 0, bus_master_enable);
    for (int d = 0; d < 5; d++) begin
      slave_acc(32'hABCD_E5A3 ^ (d << 4), d, d[0], 2'(d % 3));
    end
    slave_acc(32'h0000_0FFF, 0, 1'b1, 2'h0);
    for (int k = 0; k < 3; k++) begin
      master_cyc(32'h1234_5670 + k, 2'(k), 1'b0, 1'b0, n_sync);
    end
    master_cyc(32'h89AB_CDE0, 2'h0, 1'b1, 1'b0, n_async);
    chk("async delay", n_sync + 2, n_async);
    master_cyc(32'hFEDC_BA98, 2'h0, 1'b0, 1'b1, n_x);
    chk("held-off take", 1, n_x);
    print_verdict();
  end
endmodule : local_bus_port_tb
